/* prd_defs.svh */
// Purpose: timing counts and field constants for the pulse reference and encoder divider block
// Assumes: sys_clk at 25 MHz
// Notes: counts follow from the least widths and highest rates by the expressions below
`ifndef PRD_DEFS_SVH
`define PRD_DEFS_SVH

`define PRD_CLK_PERIOD_NS 40
`define PRD_CLK_KHZ 25000

// least pulse widths, ns
`define PRD_OC_MIN_WIDTH_NS 2500
`define PRD_LD_MIN_WIDTH_NS 1700
`define PRD_HS_MIN_WIDTH_NS 125

// highest pulse rates, kpps
`define PRD_OC_MAX_KPPS 200
`define PRD_LD_MAX_KPPS 300
`define PRD_HS_MAX_KPPS 4000

// least width rounds up to whole cycles
`define PRD_CEIL_CYC(ns) (((ns) + `PRD_CLK_PERIOD_NS - 1) / `PRD_CLK_PERIOD_NS)
// glitch filter accepts a level once stable for half the least width, at least one cycle
`define PRD_FILT_CYC(ns) ((`PRD_CEIL_CYC(ns) + 1) / 2)
// shortest legal pulse period rounds down
`define PRD_MIN_PERIOD_CYC(kpps) (`PRD_CLK_KHZ / (kpps))

`define PRD_OC_FILT_CYC `PRD_FILT_CYC(`PRD_OC_MIN_WIDTH_NS)
`define PRD_LD_FILT_CYC `PRD_FILT_CYC(`PRD_LD_MIN_WIDTH_NS)
`define PRD_HS_FILT_CYC `PRD_FILT_CYC(`PRD_HS_MIN_WIDTH_NS)
`define PRD_OC_PERIOD_CYC `PRD_MIN_PERIOD_CYC(`PRD_OC_MAX_KPPS)
`define PRD_LD_PERIOD_CYC `PRD_MIN_PERIOD_CYC(`PRD_LD_MAX_KPPS)
`define PRD_HS_PERIOD_CYC `PRD_MIN_PERIOD_CYC(`PRD_HS_MAX_KPPS)

`define PRD_CNT_W 8
`define PRD_POS_W 32
`define PRD_DIV_W 16
`define PRD_NUM_LINES 4
`define PRD_NUM_PINS 8

`endif

/* prd_pkg.sv */
// Purpose: types shared by the pulse reference and encoder divider block
// Assumes: prd_defs.svh carries all numeric constants
// Notes: none
`include "prd_defs.svh"
package prd_pkg;

  typedef enum logic [1:0] {
    PRD_FMT_PULSE_DIR,
    PRD_FMT_CW_CCW,
    PRD_FMT_QUAD
  } prd_fmt_t;

  typedef struct packed {
    prd_fmt_t low_fmt;
    prd_fmt_t fast_fmt;
    logic low_open_collector;
    logic use_fast;
    logic [`PRD_DIV_W-1:0] div_num;
    logic [`PRD_DIV_W-1:0] div_den;
  } prd_cfg_t;

  typedef struct packed {
    logic step;
    logic dir;
    logic index;
  } prd_enc_t;

  typedef struct packed {
    logic step_up;
    logic step_dn;
    logic overrate;
    logic [`PRD_POS_W-1:0] position;
  } prd_ref_t;

  typedef struct packed {
    logic a_q;
    logic b_q;
    logic up;
    logic dn;
  } prd_dec_st_t;

  typedef struct packed {
    logic [`PRD_NUM_PINS-1:0] sync1;
    logic [`PRD_NUM_PINS-1:0] sync2;
    logic [`PRD_NUM_LINES-1:0] rx;
    logic [`PRD_NUM_LINES-1:0] lvl;
    logic [`PRD_NUM_LINES-1:0][`PRD_CNT_W-1:0] cnt;
    logic [`PRD_CNT_W-1:0] low_gap;
    logic [`PRD_CNT_W-1:0] fast_gap;
    prd_ref_t ref_out;
    logic [`PRD_DIV_W-1:0] acc;
    logic [1:0] quad;
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
    logic z_pos;
    logic z_neg;
    logic z_oe_n;
  } prd_top_st_t;

endpackage

/* prd_decoder.sv */
// Purpose: turns a filtered pulse line pair into up and down steps in one of three formats
// Assumes: a and b are already synchronised and filtered on sys_clk
// Notes: quadrature counts every edge; a change of both lines at once is dropped
`timescale 1ns/1ns
module prd_decoder
  import prd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire prd_fmt_t fmt,
  input wire logic a,
  input wire logic b,
  output logic step_up,
  output logic step_dn
);

  prd_dec_st_t st_r;
  prd_dec_st_t st_nxt;

  always_comb begin
    logic rise_a;
    logic rise_b;
    logic chg_a;
    logic chg_b;
    rise_a = a & ~st_r.a_q;
    rise_b = b & ~st_r.b_q;
    chg_a = a ^ st_r.a_q;
    chg_b = b ^ st_r.b_q;
    st_nxt = st_r;
    st_nxt.a_q = a;
    st_nxt.b_q = b;
    st_nxt.up = 1'b0;
    st_nxt.dn = 1'b0;
    case (fmt)
      PRD_FMT_PULSE_DIR: begin
        // direction line low counts up
        st_nxt.up = rise_a & ~b; // RL3
        st_nxt.dn = rise_a & b; // RL3
      end
      PRD_FMT_CW_CCW: begin
        st_nxt.up = rise_a & ~rise_b; // RL3
        st_nxt.dn = rise_b & ~rise_a; // RL3
      end
      PRD_FMT_QUAD: begin
        // a leading b counts up
        if (chg_a && !chg_b) begin
          st_nxt.up = (a != b); // RL3
          st_nxt.dn = (a == b);
        end else if (chg_b && !chg_a) begin
          st_nxt.up = (a == b); // RL3
          st_nxt.dn = (a != b);
        end
      end
      default: begin
        st_nxt.up = 1'b0;
        st_nxt.dn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step_up = st_r.up;
  assign step_dn = st_r.dn;

  default clocking dec_cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  quad_both_drop_a: assert property ((fmt == PRD_FMT_QUAD) && $changed(a) && $changed(b) |=> !st_r.up && !st_r.dn) // RL3
    else $error("simultaneous quadrature change produced a step");
  dir_pulse_a: assert property ((fmt == PRD_FMT_PULSE_DIR) && $rose(a) && b |=> st_r.dn && !st_r.up) // RL3
    else $error("pulse with direction high did not count down");

endmodule

/* prd_top.sv */
// Purpose: pulse reference input on a low-speed and a fast channel, and divided encoder output
// Assumes: cfg and enc come from logic on sys_clk; reference pins are asynchronous
// Notes: div_num must not exceed div_den; div_den of zero stops the divider
//
// Notes on behaviour
// RL1: two independent reference channels, low-speed and fast; either drives the position count.
// RL2: low-speed channel takes differential or open-collector; fast channel differential only.
// RL3: each channel decodes pulse plus direction, clockwise/counter-clockwise, or A/B quadrature.
// RL4: pulse rates above 200 Kpps, 300 Kpps or 4 Mpps per input are flagged; code checks only the pulse line of the selected channel.
// RL5: pulses down to 2.5 us, 1.7 us or 0.125 us wide are accepted.
// RL6: divided encoder position leaves as A and B quadrature on differential pairs.
// RL7: home marker leaves on a differential pair and an open-collector output.
// RL8: encoder steps scaled by num/den; A/B phase order follows rotation direction.
`timescale 1ns/1ns
`include "prd_defs.svh"
module prd_top
  import prd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic low_speed_pulse_pos,
  input wire logic low_speed_pulse_neg,
  input wire logic low_speed_direction_pos,
  input wire logic low_speed_direction_neg,
  input wire logic fast_pulse_pos,
  input wire logic fast_pulse_neg,
  input wire logic fast_direction_pos,
  input wire logic fast_direction_neg,
  input wire prd_cfg_t cfg,
  input wire prd_enc_t enc,
  output prd_ref_t ref_out,
  output logic divided_phase_a_pos,
  output logic divided_phase_a_neg,
  output logic divided_phase_b_pos,
  output logic divided_phase_b_neg,
  output logic home_marker_pos,
  output logic home_marker_neg,
  input wire logic home_marker_open_collector_in,
  output logic home_marker_open_collector_out,
  output logic home_marker_open_collector_oe_n
);

  prd_top_st_t st_r;
  prd_top_st_t st_nxt;
  logic low_up;
  logic low_dn;
  logic fast_up;
  logic fast_dn;

  function automatic logic [`PRD_CNT_W-1:0] sat_inc(input logic [`PRD_CNT_W-1:0] v);
    sat_inc = (v == {`PRD_CNT_W{1'b1}}) ? v : v + `PRD_CNT_W'h01;
  endfunction

  function automatic logic [`PRD_CNT_W-1:0] filt_thr(input int line, input logic oc);
    if (line >= 2) begin
      filt_thr = `PRD_CNT_W'(`PRD_HS_FILT_CYC);
    end else if (oc) begin
      filt_thr = `PRD_CNT_W'(`PRD_OC_FILT_CYC);
    end else begin
      filt_thr = `PRD_CNT_W'(`PRD_LD_FILT_CYC);
    end
  endfunction

  prd_decoder u_low_dec (
    .sys_clk(sys_clk),
    .srst(srst),
    .fmt(cfg.low_fmt),
    .a(st_r.lvl[0]),
    .b(st_r.lvl[1]),
    .step_up(low_up),
    .step_dn(low_dn)
  );

  prd_decoder u_fast_dec (
    .sys_clk(sys_clk),
    .srst(srst),
    .fmt(cfg.fast_fmt),
    .a(st_r.lvl[2]),
    .b(st_r.lvl[3]),
    .step_up(fast_up),
    .step_dn(fast_dn)
  );

  always_comb begin
    logic pos;
    logic neg;
    logic up;
    logic dn;
    logic [`PRD_DIV_W:0] sum;
    logic [`PRD_CNT_W-1:0] low_min;
    pos = 1'b0;
    neg = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    sum = '0;
    low_min = cfg.low_open_collector ? `PRD_CNT_W'(`PRD_OC_PERIOD_CYC) : `PRD_CNT_W'(`PRD_LD_PERIOD_CYC);
    st_nxt = st_r;
    st_nxt.sync1 = {fast_direction_neg, fast_direction_pos, fast_pulse_neg, fast_pulse_pos,
                    low_speed_direction_neg, low_speed_direction_pos, low_speed_pulse_neg, low_speed_pulse_pos};
    st_nxt.sync2 = st_r.sync1;
    for (int i = 0; i < `PRD_NUM_LINES; i++) begin
      pos = st_r.sync2[2*i];
      neg = st_r.sync2[2*i+1];
      // open collector uses the single-ended line; a differential pair with equal legs holds
      if (i < 2 && cfg.low_open_collector) begin
        st_nxt.rx[i] = pos; // RL2
      end else if (pos != neg) begin
        st_nxt.rx[i] = pos; // RL2
      end
      if (st_r.rx[i] == st_r.lvl[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] + `PRD_CNT_W'h01 >= filt_thr(i, cfg.low_open_collector)) begin
        st_nxt.lvl[i] = st_r.rx[i]; // RL5
        st_nxt.cnt[i] = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + `PRD_CNT_W'h01;
      end
    end
    // pulse spacing on the pulse line of each channel
    st_nxt.low_gap = sat_inc(st_r.low_gap);
    st_nxt.fast_gap = sat_inc(st_r.fast_gap);
    st_nxt.ref_out.overrate = 1'b0;
    if (st_nxt.lvl[0] && !st_r.lvl[0]) begin
      st_nxt.low_gap = '0;
      if (!cfg.use_fast && st_r.low_gap < low_min) begin
        st_nxt.ref_out.overrate = 1'b1; // RL4
      end
    end
    if (st_nxt.lvl[2] && !st_r.lvl[2]) begin
      st_nxt.fast_gap = '0;
      if (cfg.use_fast && st_r.fast_gap < `PRD_CNT_W'(`PRD_HS_PERIOD_CYC)) begin
        st_nxt.ref_out.overrate = 1'b1; // RL4
      end
    end
    // selected channel drives the position count
    up = cfg.use_fast ? fast_up : low_up; // RL1
    dn = cfg.use_fast ? fast_dn : low_dn; // RL1
    st_nxt.ref_out.step_up = up;
    st_nxt.ref_out.step_dn = dn;
    if (up) begin
      st_nxt.ref_out.position = st_r.ref_out.position + `PRD_POS_W'h1; // RL1
    end else if (dn) begin
      st_nxt.ref_out.position = st_r.ref_out.position - `PRD_POS_W'h1; // RL1
    end
    // fractional divider: one output edge per den/num encoder steps
    if (enc.step && cfg.div_den != '0) begin
      if (!enc.dir) begin
        sum = {1'b0, st_r.acc} + {1'b0, cfg.div_num};
        if (sum >= {1'b0, cfg.div_den}) begin
          st_nxt.acc = `PRD_DIV_W'(sum - {1'b0, cfg.div_den}); // RL8
          st_nxt.quad = st_r.quad + 2'h1; // RL8
        end else begin
          st_nxt.acc = sum[`PRD_DIV_W-1:0];
        end
      end else begin
        if (st_r.acc >= cfg.div_num) begin
          st_nxt.acc = st_r.acc - cfg.div_num;
        end else begin
          sum = {1'b0, st_r.acc} + {1'b0, cfg.div_den} - {1'b0, cfg.div_num};
          st_nxt.acc = sum[`PRD_DIV_W-1:0]; // RL8
          st_nxt.quad = st_r.quad - 2'h1; // RL8
        end
      end
    end
    // forward rotation: a leads b
    st_nxt.a_pos = st_nxt.quad[0] ^ st_nxt.quad[1]; // RL6
    st_nxt.a_neg = ~(st_nxt.quad[0] ^ st_nxt.quad[1]); // RL6
    st_nxt.b_pos = st_nxt.quad[1]; // RL6
    st_nxt.b_neg = ~st_nxt.quad[1]; // RL6
    st_nxt.z_pos = enc.index; // RL7
    st_nxt.z_neg = ~enc.index; // RL7
    // open collector sinks while the marker is active
    st_nxt.z_oe_n = ~enc.index; // RL7
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.a_neg <= 1'b1;
      st_r.b_neg <= 1'b1;
      st_r.z_neg <= 1'b1;
      st_r.z_oe_n <= 1'b1;
      // no pulse seen yet, so the first pulse after reset never looks too fast
      st_r.low_gap <= 8'hff;
      st_r.fast_gap <= 8'hff;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ref_out = st_r.ref_out;
  assign divided_phase_a_pos = st_r.a_pos;
  assign divided_phase_a_neg = st_r.a_neg;
  assign divided_phase_b_pos = st_r.b_pos;
  assign divided_phase_b_neg = st_r.b_neg;
  assign home_marker_pos = st_r.z_pos;
  assign home_marker_neg = st_r.z_neg;
  assign home_marker_open_collector_out = 1'b0;
  assign home_marker_open_collector_oe_n = st_r.z_oe_n;

  default clocking top_cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  pos_track_a: assert property (ref_out.step_up |-> ref_out.position == $past(ref_out.position) + 32'h1) // RL1
    else $error("position did not advance on an up step");
  step_excl_a: assert property (!(ref_out.step_up && ref_out.step_dn)) // RL3
    else $error("up and down step together");
  fast_width_a: assert property ($changed(st_r.lvl[2]) |=> $stable(st_r.lvl[2])) // RL5
    else $error("fast filtered level toggled on consecutive cycles");
  fast_only_diff_a: assert property ((st_r.sync2[4] == st_r.sync2[5]) |=> $stable(st_r.rx[2])) // RL2
    else $error("fast receiver followed an invalid differential state");
  pair_a_a: assert property (divided_phase_a_neg == !divided_phase_a_pos) // RL6
    else $error("phase a pair not complementary");
  pair_b_a: assert property (divided_phase_b_neg == !divided_phase_b_pos) // RL6
    else $error("phase b pair not complementary");
  home_oc_a: assert property (home_marker_open_collector_oe_n == !home_marker_pos && home_marker_neg == !home_marker_pos) // RL7
    else $error("home outputs disagree");
  home_follow_a: assert property (enc.index |=> home_marker_pos ##0 !home_marker_open_collector_oe_n) // RL7
    else $error("home marker not issued");
  gray_step_a: assert property (!($changed(divided_phase_a_pos) && $changed(divided_phase_b_pos))) // RL8
    else $error("a and b changed together");
  unity_div_a: assert property (enc.step && !enc.dir && cfg.div_num == cfg.div_den && cfg.div_den != 16'h0
                                |=> st_r.quad == $past(st_r.quad) + 2'h1) // RL8
    else $error("unity ratio did not step forward");
  idle_hold_a: assert property (!enc.step |=> $stable(st_r.quad)) // RL8
    else $error("divided output moved without an encoder step");

  up_cov: cover property (ref_out.step_up);
  dn_cov: cover property (ref_out.step_dn);
  over_cov: cover property (ref_out.overrate);
  home_cov: cover property ($rose(home_marker_pos));
  quad_cov: cover property ($changed(divided_phase_b_pos));

endmodule

/* prd_host_model.sv */
// Purpose: host controller that sends a pulse reference on one channel pair
// Assumes: called from the bench just after a rising edge of sys_clk
// Notes: quadrature phase carries over between calls, so whole cycles keep lines at 00
`timescale 1ns/1ns
module prd_host_model
  import prd_pkg::*;
(
  input wire logic sys_clk,
  output logic line_a_pos,
  output logic line_a_neg,
  output logic line_b_pos,
  output logic line_b_neg
);
  logic a_r = 1'b0;
  logic b_r = 1'b0;
  logic [1:0] phase_r = 2'h0;
  logic legs_tied_r = 1'b0;

  // the direction pair is always driven opposite; the pulse pair too unless its legs are tied, as single-ended wiring would do
  assign line_a_pos = a_r;
  assign line_a_neg = legs_tied_r ? a_r : ~a_r;
  assign line_b_pos = b_r;
  assign line_b_neg = ~b_r;

  task automatic hold(input int cyc);
    repeat (cyc) @(posedge sys_clk);
  endtask

  // both legs of the pulse pair follow the pulse line while on is set
  task automatic tie_legs(input logic on);
    legs_tied_r <= on;
  endtask

  // half may fall below the least width and two halves below the least period, as the bench does to raise overrate
  task automatic send(input prd_fmt_t fmt, input logic dir, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      case (fmt)
        PRD_FMT_PULSE_DIR: begin
          b_r <= dir;
          hold(half);
          a_r <= 1'b1;
          hold(half);
          a_r <= 1'b0;
        end
        PRD_FMT_CW_CCW: begin
          hold(half);
          if (dir)
            b_r <= 1'b1;
          else
            a_r <= 1'b1;
          hold(half);
          a_r <= 1'b0;
          b_r <= 1'b0;
        end
        default: begin
          phase_r = dir ? phase_r - 2'h1 : phase_r + 2'h1;
          a_r <= (phase_r == 2'h1) || (phase_r == 2'h2);
          b_r <= phase_r[1];
          hold(2 * half);
        end
      endcase
    end
    if (fmt == PRD_FMT_PULSE_DIR)
      b_r <= 1'b0;
    hold(half);
  endtask
endmodule

/* testbench.sv */
// Purpose: self-checking bench for prd_top
// Assumes: one host model per reference channel; encoder inputs driven here
// Notes: reference and divider cases run as table rows; home marker and pin cases follow by hand
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module testbench;
  import prd_pkg::*;
  typedef struct {int ch; logic uf; logic [1:0] fmt; logic dir; int n; int half; int ovr;} prd_tb_row_t;
  // ch: 0 low differential, 1 low open-collector, 2 fast; fmt 3 selects no format and must not count
  prd_tb_row_t rows [13] = '{'{2, 1, 0, 0, 5, 4, 0}, '{2, 1, 0, 1, 3, 4, 0}, '{2, 1, 1, 0, 4, 4, 0},
    '{2, 1, 1, 1, 2, 4, 0}, '{2, 1, 2, 0, 8, 4, 0}, '{2, 1, 2, 1, 4, 4, 0}, '{0, 0, 0, 0, 3, 45, 0},
    '{0, 0, 1, 1, 2, 45, 0}, '{0, 0, 2, 0, 8, 45, 0}, '{1, 0, 0, 1, 2, 70, 0}, '{2, 0, 0, 0, 3, 4, 0},
    '{0, 0, 0, 0, 3, 30, 2}, '{2, 1, 3, 0, 4, 4, 0}};
  int dv [6][4] = '{'{1, 1, 0, 5}, '{1, 1, 1, 3}, '{1, 2, 0, 3}, '{1, 2, 1, 3}, '{2, 3, 0, 4}, '{1, 0, 0, 2}};
  logic sys_clk, srst;
  logic lo_ap, lo_an, lo_bp, lo_bn, fa_ap, fa_an, fa_bp, fa_bn;
  prd_cfg_t cfg;
  prd_enc_t enc;
  prd_ref_t ref_out;
  logic a_pos, a_neg, b_pos, b_neg, z_pos, z_neg, oc_out, oc_oe_n, oc_wire;
  logic [31:0] exp_pos;
  logic [1:0] q;
  int n_errors = 0;
  int num_checks = 0;
  int n_over = 0;
  int n_up = 0;
  int n_dn = 0;
  int acc, ov0;

  // open-collector home line with a pull-up
  assign oc_wire = oc_oe_n ? 1'b1 : oc_out;

  prd_host_model i_host_low (.sys_clk(sys_clk), .line_a_pos(lo_ap), .line_a_neg(lo_an), .line_b_pos(lo_bp),
    .line_b_neg(lo_bn));
  prd_host_model i_host_fast (.sys_clk(sys_clk), .line_a_pos(fa_ap), .line_a_neg(fa_an), .line_b_pos(fa_bp),
    .line_b_neg(fa_bn));
  prd_top i_dut (.sys_clk(sys_clk), .srst(srst), .low_speed_pulse_pos(lo_ap), .low_speed_pulse_neg(lo_an),
    .low_speed_direction_pos(lo_bp), .low_speed_direction_neg(lo_bn), .fast_pulse_pos(fa_ap),
    .fast_pulse_neg(fa_an), .fast_direction_pos(fa_bp), .fast_direction_neg(fa_bn), .cfg(cfg), .enc(enc),
    .ref_out(ref_out), .divided_phase_a_pos(a_pos), .divided_phase_a_neg(a_neg), .divided_phase_b_pos(b_pos),
    .divided_phase_b_neg(b_neg), .home_marker_pos(z_pos), .home_marker_neg(z_neg),
    .home_marker_open_collector_in(oc_wire), .home_marker_open_collector_out(oc_out),
    .home_marker_open_collector_oe_n(oc_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (ref_out.overrate === 1'b1)
      n_over <= n_over + 1;
    if (ref_out.step_up === 1'b1)
      n_up <= n_up + 1;
    if (ref_out.step_dn === 1'b1)
      n_dn <= n_dn + 1;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // mirrors the num/den accumulator and quadrature count
  task automatic enc_step(input logic d, input int num, input int den);
    logic [1:0] ab;
    @(posedge sys_clk);
    enc.step <= 1'b1;
    enc.dir <= d;
    @(posedge sys_clk);
    enc.step <= 1'b0;
    if (den != 0 && !d) begin
      acc = acc + num;
      if (acc >= den) begin
        acc = acc - den;
        q = q + 2'h1;
      end
    end else if (den != 0) begin
      if (acc >= num)
        acc = acc - num;
      else begin
        acc = acc + den - num;
        q = q - 2'h1;
      end
    end
    ab = {(q == 2'h1) || (q == 2'h2), q[1]};
    @(negedge sys_clk);
    `CHK({a_pos, b_pos}, ab)
    `CHK({a_neg, b_neg}, ~ab)
  endtask

  initial begin
    srst = 1'b1;
    cfg = '0;
    cfg.div_num = 16'h0001;
    cfg.div_den = 16'h0001;
    enc = '0;
    exp_pos = '0;
    acc = 0;
    q = 2'h0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ref_out, 35'h0)
    `CHK({a_pos, a_neg, b_pos, b_neg, z_pos, z_neg, oc_oe_n}, 7'h2b)
    @(posedge sys_clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      cfg.low_fmt <= prd_fmt_t'(rows[i].fmt);
      cfg.fast_fmt <= prd_fmt_t'(rows[i].fmt);
      cfg.use_fast <= rows[i].uf;
      cfg.low_open_collector <= (rows[i].ch == 1);
      repeat (4) @(posedge sys_clk);
      ov0 = n_over;
      if (rows[i].ch == 2)
        i_host_fast.send(prd_fmt_t'(rows[i].fmt), rows[i].dir, rows[i].n, rows[i].half);
      else
        i_host_low.send(prd_fmt_t'(rows[i].fmt), rows[i].dir, rows[i].n, rows[i].half);
      repeat (60) @(posedge sys_clk);
      @(negedge sys_clk);
      if (rows[i].uf == (rows[i].ch == 2) && rows[i].fmt != 2'h3)
        exp_pos = rows[i].dir ? exp_pos - 32'(rows[i].n) : exp_pos + 32'(rows[i].n);
      `CHK(ref_out.position, exp_pos)
      `CHK(n_over - ov0, rows[i].ovr)
    end
    foreach (dv[j]) begin
      @(posedge sys_clk);
      cfg.div_num <= 16'(dv[j][0]);
      cfg.div_den <= 16'(dv[j][1]);
      repeat (dv[j][3]) enc_step(dv[j][2] != 0, dv[j][0], dv[j][1]);
    end
    @(posedge sys_clk);
    enc.index <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({z_pos, z_neg, oc_oe_n, oc_wire}, 4'h8)
    @(posedge sys_clk);
    enc.index <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({z_pos, z_neg, oc_oe_n, oc_wire}, 4'h7)
    // fast pair with equal legs is refused
    @(posedge sys_clk);
    cfg.fast_fmt <= PRD_FMT_PULSE_DIR;
    i_host_fast.tie_legs(1'b1);
    repeat (4) @(posedge sys_clk);
    i_host_fast.send(PRD_FMT_PULSE_DIR, 1'b0, 2, 4);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ref_out.position, exp_pos)
    // open-collector low channel reads only its positive pin
    @(posedge sys_clk);
    i_host_fast.tie_legs(1'b0);
    i_host_low.tie_legs(1'b1);
    cfg.use_fast <= 1'b0;
    cfg.low_fmt <= PRD_FMT_PULSE_DIR;
    cfg.low_open_collector <= 1'b1;
    repeat (4) @(posedge sys_clk);
    i_host_low.send(PRD_FMT_PULSE_DIR, 1'b0, 2, 70);
    repeat (60) @(posedge sys_clk);
    @(negedge sys_clk);
    exp_pos = exp_pos + 32'h2;
    `CHK(ref_out.position, exp_pos)
    `CHK(32'(n_up - n_dn), exp_pos)
    // reset in mid-run; the first pulse after it must not look too fast
    @(posedge sys_clk);
    i_host_low.tie_legs(1'b0);
    cfg.low_open_collector <= 1'b0;
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ref_out, 35'h0)
    `CHK({a_pos, a_neg, b_pos, b_neg, z_pos, z_neg, oc_oe_n}, 7'h2b)
    @(posedge sys_clk);
    srst <= 1'b0;
    ov0 = n_over;
    i_host_low.send(PRD_FMT_PULSE_DIR, 1'b0, 1, 45);
    repeat (60) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ref_out.position, 32'h1)
    `CHK(n_over - ov0, 0)
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
endmodule
